// *** dv/sifd_ctrl_model.sv ***
// external controller model: closes contacts to signal ground
// assumes the bench changes the mask just after a clock edge
`timescale 1ns/100ps
module sifd_ctrl_model (
    input wire logic [sifd_pkg::N_PINS-1:0] closed, // contacts to close
    output logic [sifd_pkg::N_PINS-1:0] in_pin_n // pins, low = closed
);
    // closed contact pulls the pin low
    assign in_pin_n = ~closed;
endmodule : sifd_ctrl_model

// *** dv/sifd_decoder_checker.sv ***
// port checker for the servo input function decoder
// assumes bind onto sifd_decoder, one clock domain, sync reset
`timescale 1ns/100ps
module sifd_decoder_checker #(
    parameter int NUM_W = 32
) (
    input wire logic clk, // drive clock
    input wire logic reset, // sync reset
    input wire logic [sifd_pkg::N_PINS-1:0] in_pin_n, // contacts
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [7:0] wb_adr_i, // address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // ack
    input wire logic fwd_torque_en, // forward torque
    input wire logic rev_torque_en, // reverse torque
    input wire logic origin_set_pulse, // origin load
    input wire logic homing_start_pulse, // homing start
    input wire logic [1:0] gear_index, // gear index
    input wire logic [NUM_W-1:0] gear_numerator, // numerator
    input wire logic droop_clear, // clear
    input wire logic gain_mult_sel, // gain switch
    input wire logic [1:0] ctrl_mode_active // running loop
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic [7:0] open_cnt_r;
    logic [7:0] open_cnt_nxt;
    // ----------------------------------------
    // helper: cycles with every contact open
    // ----------------------------------------
    // saturates so a long idle spell never wraps back to zero
    always_comb begin
        open_cnt_nxt = open_cnt_r;
        if (in_pin_n != 8'hFF) begin
            open_cnt_nxt = 8'h00;
        end else if (open_cnt_r != 8'hFF) begin
            open_cnt_nxt = open_cnt_r + 8'h01;
        end
    end
    // register the idle count
    always_ff @(posedge clk) begin
        if (reset) begin
            open_cnt_r <= 8'h00;
        end else begin
            open_cnt_r <= open_cnt_nxt;
        end
    end
    // ----------------------------------------
    // bus handshake steps
    // ----------------------------------------
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_open_quiet;
        open_cnt_r >= 8'h8C |-> !fwd_torque_en && !rev_torque_en &&
            !gain_mult_sel && !droop_clear && !origin_set_pulse &&
            !homing_start_pulse && gear_index == 2'b00;
    endproperty
    a_bus_answer: assert property (s_take |=> s_answer)
        else $error("ack not one cycle after request");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without a request");
    a_torque_excl: assert property (!(fwd_torque_en && rev_torque_en))
        else $error("both torque outputs high");
    a_origin_pulse: assert property (
        origin_set_pulse |=> !origin_set_pulse)
        else $error("origin pulse longer than one cycle");
    a_homing_pulse: assert property (
        homing_start_pulse |=> !homing_start_pulse)
        else $error("homing pulse longer than one cycle");
    a_mode_legal: assert property (ctrl_mode_active != 2'b11)
        else $error("illegal active loop code");
    a_open_quiet: assert property (p_open_quiet)
        else $error("output asserted with all contacts open");
    a_reset_values: assert property ($fell(reset) |->
        gear_numerator == 1 && ctrl_mode_active == 2'b00)
        else $error("bad output values after reset");
endmodule : sifd_decoder_checker

bind sifd_decoder sifd_decoder_checker #(.NUM_W(NUM_W)) u_chk (
    .clk(clk), .reset(reset), .in_pin_n(in_pin_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fwd_torque_en(fwd_torque_en),
    .rev_torque_en(rev_torque_en), .origin_set_pulse(origin_set_pulse),
    .homing_start_pulse(homing_start_pulse), .gear_index(gear_index),
    .gear_numerator(gear_numerator), .droop_clear(droop_clear),
    .gain_mult_sel(gain_mult_sel), .ctrl_mode_active(ctrl_mode_active));

// *** dv/tb_servo_input_function_decoder.sv ***
// testbench for the servo input function decoder
// assumes sifd_pkg, the decoder, its checker and the contact model
`timescale 1ns/100ps
module tb_servo_input_function_decoder;
    typedef struct packed {
        logic [7:0] pins;
        logic [3:0] ctrl;
        logic [1:0] tq;
        logic [1:0] gi;
        logic gain;
        logic [1:0] act;
    } sifd_row_s;
    logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] closed, in_pin_n, wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q, gear_numerator;
    logic fwd, rev, org, hom, dclr, gain;
    logic [1:0] gi, act;
    int fails, num_checks;
    integer c_org, c_hom, c_clr, c_fwd;
    sifd_row_s rows [14] = '{
        '{8'h00, 4'h0, 2'b00, 2'h0, 1'b0, 2'h0},
        '{8'h01, 4'h0, 2'b10, 2'h0, 1'b0, 2'h0},
        '{8'h02, 4'h0, 2'b01, 2'h0, 1'b0, 2'h0},
        '{8'h03, 4'h0, 2'b00, 2'h0, 1'b0, 2'h0},
        '{8'h04, 4'h0, 2'b00, 2'h1, 1'b0, 2'h0},
        '{8'h08, 4'h0, 2'b00, 2'h2, 1'b0, 2'h0},
        '{8'h0C, 4'h0, 2'b00, 2'h3, 1'b0, 2'h0},
        '{8'h0C, 4'h4, 2'b00, 2'h0, 1'b0, 2'h0},
        '{8'h20, 4'h0, 2'b00, 2'h0, 1'b1, 2'h0},
        '{8'h40, 4'h0, 2'b00, 2'h0, 1'b0, 2'h0},
        '{8'h40, 4'h2, 2'b00, 2'h0, 1'b0, 2'h1},
        '{8'h00, 4'h2, 2'b00, 2'h0, 1'b0, 2'h0},
        '{8'h40, 4'h3, 2'b00, 2'h0, 1'b0, 2'h2},
        '{8'h00, 4'h3, 2'b00, 2'h0, 1'b0, 2'h1}};
    // ----------------------------------------
    // clock, model and design
    // ----------------------------------------
    always #4 clk = ~clk;
    sifd_ctrl_model u_ctrl (.closed(closed), .in_pin_n(in_pin_n));
    sifd_decoder uut (.clk(clk), .reset(reset), .in_pin_n(in_pin_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fwd_torque_en(fwd),
        .rev_torque_en(rev), .origin_set_pulse(org),
        .homing_start_pulse(hom), .gear_index(gi),
        .gear_numerator(gear_numerator), .droop_clear(dclr),
        .gain_mult_sel(gain), .ctrl_mode_active(act));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one classic cycle; held until ack is sampled high
    task automatic xfer(input logic we, input logic [7:0] a,
                        input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc
    // count pulse outputs and forward torque over a span
    task automatic tally(input int n);
        c_org = 0;
        c_hom = 0;
        c_clr = 0;
        c_fwd = 0;
        repeat (n) begin
            @(posedge clk);
            c_org += org;
            c_hom += hom;
            c_clr += dclr;
            c_fwd += fwd;
        end
    endtask : tally
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    // watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        closed = 8'h00;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        xfer(1'b0, sifd_pkg::CTRL_OFS, 4'hF, 32'h0);
        check(q, 32'h0);
        xfer(1'b0, sifd_pkg::NUM_ONE_OFS, 4'hF, 32'h0);
        check(q, sifd_pkg::NUM_RST);
        xfer(1'b0, 8'h20, 4'hF, 32'h0);
        check(q, 32'h0);
        // closed pins with no function assigned do nothing
        closed <= 8'hFF;
        wait_cyc(140);
        check({fwd, rev, gi, gain}, 32'h0);
        closed <= 8'h00;
        wait_cyc(140);
        xfer(1'b1, sifd_pkg::PIN_ASSIGN_LO_OFS, 4'hF, 32'h0E0D_090A);
        xfer(1'b1, sifd_pkg::PIN_ASSIGN_HI_OFS, 4'hF, 32'h0B11_100F);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, sifd_pkg::NUM_ONE_OFS + 8'(4 * i), 4'hF,
                 32'h11 * (i + 1));
        end
        foreach (rows[i]) begin
            xfer(1'b1, sifd_pkg::CTRL_OFS, 4'hF, {28'h0, rows[i].ctrl});
            closed <= rows[i].pins;
            wait_cyc(140);
            check({fwd, rev}, rows[i].tq);
            check(gi, rows[i].gi);
            check(gear_numerator, 32'h11 * (rows[i].gi + 1));
            check(gain, rows[i].gain);
            check(act, rows[i].act);
        end
        xfer(1'b1, sifd_pkg::CTRL_OFS, 4'hF, 32'h0);
        closed <= 8'h00;
        wait_cyc(140);
        // a short closure never reaches the outputs
        closed <= 8'h01;
        wait_cyc(50);
        closed <= 8'h00;
        tally(200);
        check(c_fwd, 0);
        // clear request held long, one pulse on the leading edge
        // clear held 300 cycles, far short of 10 ms
        closed <= 8'h10;
        tally(300);
        check(c_clr, 1);
        closed <= 8'h00;
        tally(200);
        check(c_clr, 0);
        xfer(1'b1, sifd_pkg::CTRL_OFS, 4'h1, 32'h8);
        closed <= 8'h10;
        wait_cyc(140);
        tally(100);
        check(c_clr, 100);
        closed <= 8'h00;
        wait_cyc(140);
        check(dclr, 1'b0);
        // origin acts only in internal-register position mode
        xfer(1'b1, sifd_pkg::CTRL_OFS, 4'hF, 32'h0);
        closed <= 8'h80;
        tally(200);
        check(c_org, 0);
        closed <= 8'h00;
        wait_cyc(140);
        xfer(1'b1, sifd_pkg::CTRL_OFS, 4'hF, 32'h1);
        closed <= 8'h80;
        tally(200);
        check(c_org, 1);
        closed <= 8'h00;
        wait_cyc(140);
        // byte-enable write moves pin7 to homing only
        xfer(1'b1, sifd_pkg::PIN_ASSIGN_HI_OFS, 4'h8, 32'h0C00_0000);
        xfer(1'b0, sifd_pkg::PIN_ASSIGN_HI_OFS, 4'hF, 32'h0);
        check(q, 32'h0C11_100F);
        closed <= 8'h80;
        tally(200);
        check({c_hom[7:0], c_org[7:0]}, 16'h0100);
        xfer(1'b0, sifd_pkg::STATUS_OFS, 4'hF, 32'h0);
        check(q, 32'h8000_0800);
        // mid-run reset: registers and outputs back to defaults
        reset <= 1'b1;
        wait_cyc(2);
        reset <= 1'b0;
        @(posedge clk);
        check({fwd, rev, org, hom, gi, dclr, gain, act}, 32'h0);
        check(gear_numerator, sifd_pkg::NUM_RST);
        xfer(1'b0, sifd_pkg::PIN_ASSIGN_HI_OFS, 4'hF, 32'h0);
        check(q, 32'h0);
        final_report();
    end
endmodule : tb_servo_input_function_decoder

// *** verilog/sifd_decoder.sv ***
// servo input function decoder: discrete contact inputs to drive controls
// assumes pins already at clock level, low when closed to signal ground,
// and a classic wishbone master on the register port
//
// Overview of operation
// - closed contact asserts, open contact deasserts
// - equal torque options give no torque
// - forward option alone: forward torque
// - reverse option alone: reverse torque
// - origin-set stores position in register mode
// - homing-start returns motor in register mode
// - gear selects work only once assigned
// - two gear selects form 2-bit index
// - index 00..11 picks numerator one..four
// - gear selects ignored in absolute system
// - clear rising edge clears droop pulses
// - level clear mode clears while asserted
// - assigned gain switch applies gain multipliers
// - position/speed mode: select picks speed
// - speed/torque mode: select picks torque
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module sifd_decoder #(
    parameter int NUM_W = 32
) (
    input wire logic clk, // 125 MHz drive clock
    input wire logic reset, // synchronous, active high
    input wire logic [sifd_pkg::N_PINS-1:0] in_pin_n, // contacts, low=closed
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // transfer done
    output logic fwd_torque_en, // forward torque, reverse regen
    output logic rev_torque_en, // reverse torque, forward regen
    output logic origin_set_pulse, // load current position as origin
    output logic homing_start_pulse, // start move back to origin
    output logic [1:0] gear_index, // selected numerator index
    output logic [NUM_W-1:0] gear_numerator, // selected numerator
    output logic droop_clear, // clear deviation counter
    output logic gain_mult_sel, // apply gain multipliers
    output logic [1:0] ctrl_mode_active // running loop
);
    // ----------------------------------------
    // input conditioning
    // ----------------------------------------
    logic [sifd_pkg::N_PINS-1:0] pin_on;
    genvar gp;
    generate
        for (gp = 0; gp < sifd_pkg::N_PINS; gp++) begin : g_pin
            logic meta_r, sync_r, stable_r, stable_nxt;
            logic [sifd_pkg::DB_W-1:0] cnt_r, cnt_nxt;
            // debounce filter
            // level must hold a full filter time before it is believed
            always_comb begin
                cnt_nxt = '0;
                stable_nxt = stable_r;
                if (sync_r != stable_r) begin
                    if (cnt_r >= sifd_pkg::DB_CYC_C - 8'h01) begin
                        stable_nxt = sync_r;
                    end else begin
                        cnt_nxt = cnt_r + 8'h01;
                    end
                end
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                    stable_r <= 1'b1;
                    cnt_r <= '0;
                end else begin
                    meta_r <= in_pin_n[gp];
                    sync_r <= meta_r;
                    stable_r <= stable_nxt;
                    cnt_r <= cnt_nxt;
                end
            end
            assign pin_on[gp] = ~stable_r;
        end
    endgenerate

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [sifd_pkg::N_PINS-1:0][7:0] pin_fn_r, pin_fn_nxt;
    logic [3:0] ctrl_r, ctrl_nxt;
    logic [3:0][NUM_W-1:0] num_r, num_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] status;
    logic req;
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    // merge a write word into an old word by byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_be
    // bus writes and read mux; answer one cycle after the request
    // unmapped addresses ack, read zero, and ignore writes
    always_comb begin
        logic [31:0] w;
        w = '0;
        pin_fn_nxt = pin_fn_r;
        ctrl_nxt = ctrl_r;
        num_nxt = num_r;
        rdat_nxt = rdat_r;
        ack_nxt = req;
        if (req) begin
            rdat_nxt = '0;
            case (wb_adr_i)
                sifd_pkg::PIN_ASSIGN_LO_OFS: begin
                    rdat_nxt = pin_fn_r[3:0];
                    w = merge_be(pin_fn_r[3:0], wb_dat_i, wb_sel_i);
                    if (wb_we_i) begin
                        pin_fn_nxt[3:0] = w;
                    end
                end
                sifd_pkg::PIN_ASSIGN_HI_OFS: begin
                    rdat_nxt = pin_fn_r[7:4];
                    w = merge_be(pin_fn_r[7:4], wb_dat_i, wb_sel_i);
                    if (wb_we_i) begin
                        pin_fn_nxt[7:4] = w;
                    end
                end
                sifd_pkg::CTRL_OFS: begin
                    rdat_nxt = {28'h0000000, ctrl_r};
                    if (wb_we_i && wb_sel_i[0]) begin
                        ctrl_nxt = wb_dat_i[3:0];
                    end
                end
                sifd_pkg::STATUS_OFS: begin
                    rdat_nxt = status;
                end
                sifd_pkg::NUM_ONE_OFS,
                sifd_pkg::NUM_TWO_OFS,
                sifd_pkg::NUM_THREE_OFS,
                sifd_pkg::NUM_FOUR_OFS: begin
                    rdat_nxt = 32'(num_r[wb_adr_i[3:2]]);
                    w = merge_be(32'(num_r[wb_adr_i[3:2]]), wb_dat_i,
                                 wb_sel_i);
                    if (wb_we_i) begin
                        num_nxt[wb_adr_i[3:2]] = w[NUM_W-1:0];
                    end
                end
                default: begin
                    rdat_nxt = '0;
                end
            endcase
        end
    end
    // register file storage
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_fn_r <= {sifd_pkg::N_PINS{sifd_pkg::PIN_FN_RST}};
            ctrl_r <= sifd_pkg::CTRL_RST;
            num_r <= {4{sifd_pkg::NUM_RST[NUM_W-1:0]}};
            rdat_r <= '0;
            ack_r <= 1'b0;
        end else begin
            pin_fn_r <= pin_fn_nxt;
            ctrl_r <= ctrl_nxt;
            num_r <= num_nxt;
            rdat_r <= rdat_nxt;
            ack_r <= ack_nxt;
        end
    end
    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;
    // ----------------------------------------
    // function routing
    // ----------------------------------------
    // pin carries a function when its code matches
    // a function that no pin carries stays deasserted
    function automatic logic fn_hit(
        input logic [7:0] code,
        input logic [sifd_pkg::N_PINS-1:0][7:0] fns,
        input logic [sifd_pkg::N_PINS-1:0] on);
        logic hit;
        hit = 1'b0;
        for (int p = 0; p < sifd_pkg::N_PINS; p++) begin
            if (fns[p] == code && on[p]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : fn_hit

    logic fwd_torque_option, rev_torque_option, origin_set_input;
    logic homing_start_input, gear_select_lo, gear_select_hi;
    logic droop_clear_input, gain_switch_input, mode_select_input;
    always_comb begin
        fwd_torque_option = fn_hit(sifd_pkg::FN_FWD_TORQUE, pin_fn_r, pin_on);
        rev_torque_option = fn_hit(sifd_pkg::FN_REV_TORQUE, pin_fn_r, pin_on);
        origin_set_input = fn_hit(sifd_pkg::FN_ORIGIN_SET, pin_fn_r, pin_on);
        homing_start_input = fn_hit(sifd_pkg::FN_HOMING, pin_fn_r, pin_on);
        gear_select_lo = fn_hit(sifd_pkg::FN_GEAR_LO, pin_fn_r, pin_on);
        gear_select_hi = fn_hit(sifd_pkg::FN_GEAR_HI, pin_fn_r, pin_on);
        droop_clear_input = fn_hit(sifd_pkg::FN_DROOP_CLR, pin_fn_r, pin_on);
        gain_switch_input = fn_hit(sifd_pkg::FN_GAIN_SW, pin_fn_r, pin_on);
        mode_select_input = fn_hit(sifd_pkg::FN_MODE_SEL, pin_fn_r, pin_on);
    end

    // ----------------------------------------
    // decode of drive controls
    // ----------------------------------------
    sifd_pkg::sifd_mode_e mode;
    logic abs_system, clear_level_mode;
    logic org_prev_r, org_prev_nxt, hom_prev_r, hom_prev_nxt;
    logic clr_prev_r, clr_prev_nxt, fwd_r, fwd_nxt, rev_r, rev_nxt;
    logic org_r, org_nxt, hom_r, hom_nxt, clr_r, clr_nxt, gain_r, gain_nxt;
    logic [1:0] gidx_r, gidx_nxt, act_r, act_nxt;
    logic [NUM_W-1:0] gnum_r, gnum_nxt;
    assign mode = sifd_pkg::sifd_mode_e'(ctrl_r[sifd_pkg::CTRL_MODE_LSB +: 2]);
    assign abs_system = ctrl_r[sifd_pkg::CTRL_ABS_BIT];
    assign clear_level_mode = ctrl_r[sifd_pkg::CTRL_CLR_LVL_BIT];
    // next values of every control output
    always_comb begin
        org_prev_nxt = origin_set_input;
        hom_prev_nxt = homing_start_input;
        clr_prev_nxt = droop_clear_input;
        // both equal: no torque at all
        fwd_nxt = fwd_torque_option & ~rev_torque_option;
        rev_nxt = rev_torque_option & ~fwd_torque_option;
        org_nxt = (mode == sifd_pkg::SIFD_INT_REG_POS) &
                  origin_set_input & ~org_prev_r;
        hom_nxt = (mode == sifd_pkg::SIFD_INT_REG_POS) &
                  homing_start_input & ~hom_prev_r;
        gidx_nxt = {gear_select_hi, gear_select_lo};
        if (abs_system) begin
            gidx_nxt = 2'h0;
        end
        // index picks numerator
        // picked from the next index so index and value move together
        gnum_nxt = num_r[gidx_nxt];
        clr_nxt = droop_clear_input & ~clr_prev_r;
        if (clear_level_mode) begin
            clr_nxt = droop_clear_input;
        end
        gain_nxt = gain_switch_input;
        case (mode)
            sifd_pkg::SIFD_POS_SPEED: begin
                act_nxt = mode_select_input ? sifd_pkg::SIFD_ACT_SPEED
                                            : sifd_pkg::SIFD_ACT_POSITION;
            end
            sifd_pkg::SIFD_SPEED_TORQUE: begin
                act_nxt = mode_select_input ? sifd_pkg::SIFD_ACT_TORQUE
                                            : sifd_pkg::SIFD_ACT_SPEED;
            end
            default: begin
                act_nxt = sifd_pkg::SIFD_ACT_POSITION;
            end
        endcase
    end
    // control output registers
    // edge history resets deasserted, so a contact held closed
    // through reset gives an edge on the first filtered cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            org_prev_r <= 1'b0;
            hom_prev_r <= 1'b0;
            clr_prev_r <= 1'b0;
            fwd_r <= 1'b0;
            rev_r <= 1'b0;
            org_r <= 1'b0;
            hom_r <= 1'b0;
            gidx_r <= 2'h0;
            gnum_r <= sifd_pkg::NUM_RST[NUM_W-1:0];
            clr_r <= 1'b0;
            gain_r <= 1'b0;
            act_r <= sifd_pkg::SIFD_ACT_POSITION;
        end else begin
            org_prev_r <= org_prev_nxt;
            hom_prev_r <= hom_prev_nxt;
            clr_prev_r <= clr_prev_nxt;
            fwd_r <= fwd_nxt;
            rev_r <= rev_nxt;
            org_r <= org_nxt;
            hom_r <= hom_nxt;
            gidx_r <= gidx_nxt;
            gnum_r <= gnum_nxt;
            clr_r <= clr_nxt;
            gain_r <= gain_nxt;
            act_r <= act_nxt;
        end
    end
    // status word for software
    always_comb begin
        status = '0;
        status[sifd_pkg::ST_FWD_BIT] = fwd_r;
        status[sifd_pkg::ST_REV_BIT] = rev_r;
        status[sifd_pkg::ST_GEAR_LSB +: 2] = gidx_r;
        status[sifd_pkg::ST_CLR_BIT] = clr_r;
        status[sifd_pkg::ST_GAIN_BIT] = gain_r;
        status[sifd_pkg::ST_ACT_LSB +: 2] = act_r;
        status[sifd_pkg::ST_FN_LSB +: 9] = {mode_select_input,
            gain_switch_input, droop_clear_input, gear_select_hi,
            gear_select_lo, homing_start_input, origin_set_input,
            rev_torque_option, fwd_torque_option};
        status[sifd_pkg::ST_PIN_LSB +: sifd_pkg::N_PINS] = pin_on;
    end
    // outputs straight from flops
    assign fwd_torque_en = fwd_r;
    assign rev_torque_en = rev_r;
    assign origin_set_pulse = org_r;
    assign homing_start_pulse = hom_r;
    assign gear_index = gidx_r;
    assign gear_numerator = gnum_r;
    assign droop_clear = clr_r;
    assign gain_mult_sel = gain_r;
    assign ctrl_mode_active = act_r;
endmodule : sifd_decoder

// *** verilog/sifd_pkg.sv ***
// constants and types for the servo input function decoder
// assumes a 125 MHz clock and a 32-bit classic wishbone register port
package sifd_pkg;
    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_MHZ = 125;
    // contact bounce filter time in ns
    localparam int DB_NS = 1000;
    // least time rounds up to whole cycles
    localparam int DB_CYC = (DB_NS * CLK_MHZ + 999) / 1000;
    localparam int DB_W = 8;
    localparam logic [DB_W-1:0] DB_CYC_C = DB_CYC[DB_W-1:0];

    // ----------------------------------------
    // physical pins
    // ----------------------------------------
    localparam int N_PINS = 8;

    // ----------------------------------------
    // function selection codes
    // ----------------------------------------
    localparam logic [7:0] FN_REV_TORQUE = 8'h09;
    localparam logic [7:0] FN_FWD_TORQUE = 8'h0A;
    localparam logic [7:0] FN_ORIGIN_SET = 8'h0B;
    localparam logic [7:0] FN_HOMING = 8'h0C;
    localparam logic [7:0] FN_GEAR_LO = 8'h0D;
    localparam logic [7:0] FN_GEAR_HI = 8'h0E;
    localparam logic [7:0] FN_DROOP_CLR = 8'h0F;
    localparam logic [7:0] FN_GAIN_SW = 8'h10;
    localparam logic [7:0] FN_MODE_SEL = 8'h11;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] PIN_ASSIGN_LO_OFS = 8'h00;
    localparam logic [7:0] PIN_ASSIGN_HI_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] NUM_ONE_OFS = 8'h10;
    localparam logic [7:0] NUM_TWO_OFS = 8'h14;
    localparam logic [7:0] NUM_THREE_OFS = 8'h18;
    localparam logic [7:0] NUM_FOUR_OFS = 8'h1C;

    // ----------------------------------------
    // control register fields and reset values
    // ----------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ABS_BIT = 2;
    localparam int CTRL_CLR_LVL_BIT = 3;
    localparam logic [7:0] PIN_FN_RST = 8'h00;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [31:0] NUM_RST = 32'h0000_0001;

    // ----------------------------------------
    // status register fields
    // ----------------------------------------
    localparam int ST_FWD_BIT = 0;
    localparam int ST_REV_BIT = 1;
    localparam int ST_GEAR_LSB = 2;
    localparam int ST_CLR_BIT = 4;
    localparam int ST_GAIN_BIT = 5;
    localparam int ST_ACT_LSB = 6;
    localparam int ST_FN_LSB = 8;
    localparam int ST_PIN_LSB = 24;

    // drive operating modes
    typedef enum logic [1:0] {
        SIFD_PULSE_TRAIN_POS = 2'b00,
        SIFD_INT_REG_POS = 2'b01,
        SIFD_POS_SPEED = 2'b10,
        SIFD_SPEED_TORQUE = 2'b11
    } sifd_mode_e;

    // loop that is actually running
    typedef enum logic [1:0] {
        SIFD_ACT_POSITION = 2'b00,
        SIFD_ACT_SPEED = 2'b01,
        SIFD_ACT_TORQUE = 2'b10
    } sifd_act_e;
endpackage : sifd_pkg
